/* design/irw_pkg.sv */
// constants and types for the initial reset and watchdog block
// assumes a single 100 MHz aclk domain and AXI4-Lite register access
package irw_pkg;

    // clock rate and documented minimum times
    localparam int unsigned CLK_MHZ       = 100;        // aclk rate in MHz
    localparam int unsigned PIN_LOW_US    = 2000;       // reset pulse minimum, 2 ms
    localparam int unsigned KEY_LOW_MS    = 2000;       // key combination minimum, 2 s
    localparam int unsigned PIN_CYCLES    = PIN_LOW_US * CLK_MHZ;          // least time, exact
    localparam int unsigned KEY_CYCLES    = KEY_LOW_MS * 1000 * CLK_MHZ;   // least time, exact
    localparam int unsigned WDT_HOLD      = 16;         // cycles a watchdog reset is stretched

    // watchdog: fires on the fourth 1 Hz tick after a clear, i.e. 3 to 4 s
    localparam logic [2:0]  DOG_LIMIT     = 3'h4;

    // key combination build option
    localparam logic [1:0]  KEYSEL_OFF    = 2'h0;       // key reset unused
    localparam logic [1:0]  KEYSEL_01     = 2'h1;       // lines 0 and 1
    localparam logic [1:0]  KEYSEL_012    = 2'h2;       // lines 0 to 2
    localparam logic [1:0]  KEYSEL_0123   = 2'h3;       // lines 0 to 3

    // register map: printed offsets are indices, byte address is four times
    localparam logic [13:0] CLEAR_IDX     = 14'hF76;    // timer_and_watchdog_clear
    localparam logic [13:0] STATUS_IDX    = 14'hF77;    // source and counter status
    localparam logic [15:0] CLEAR_ADDR    = {CLEAR_IDX, 2'b00};
    localparam logic [15:0] STATUS_ADDR   = {STATUS_IDX, 2'b00};
    localparam int unsigned DOG_CLR_BIT   = 0;          // dog_counter_clear_bit
    localparam int unsigned TMR_CLR_BIT   = 1;          // tick_timer_clear_bit

    // axi responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // cpu core values loaded at initial reset
    typedef struct packed {
        logic [7:0] program_step_counter;
        logic [3:0] program_page_counter;
        logic       program_bank_bit;
        logic [3:0] next_page_pointer;
        logic       next_bank_pointer;
        logic       interrupt_flag;
        logic       decimal_flag;
    } irw_cpu_init_t;

    localparam irw_cpu_init_t CPU_INIT = '{
        program_step_counter: 8'h00,
        program_page_counter: 4'h1,
        program_bank_bit:     1'h0,
        next_page_pointer:    4'h1,
        next_bank_pointer:    1'h0,
        interrupt_flag:       1'h0,
        decimal_flag:         1'h0
    };

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        IRW_RUN  = 2'b01,
        IRW_HOLD = 2'b10
    } irw_state_t;

endpackage : irw_pkg

/* design/irw_init_reset.sv */
// initial reset sequencer with pin filter, key qualifier, oscillation
// detector input and watchdog, plus an AXI4-Lite register slave.
// assumes pins arrive asynchronously; watchdog tick comes from aclk logic.
//
// Overview of operation
// - four sources: pin, keys, oscillator, watchdog
// - reset while pin low, run when high
// - pin must stay low 2 ms to count
// - keys low together 2 s before reset
// - key combination fixed by build option
// - hold reset until oscillator starts
// - watchdog counts 1 Hz, fires after 3-4 s
// - watchdog keeps counting during cpu halt
// - write 1 clears watchdog, 0 does nothing
// - clear register reads back as zero
// - timer clear bumps watchdog by one
// - cpu loads fixed start values on reset
`timescale 1ns/1ps
module irw_init_reset #(
    parameter int unsigned PIN_CYC  = irw_pkg::PIN_CYCLES,  // pin filter length
    parameter int unsigned KEY_CYC  = irw_pkg::KEY_CYCLES,  // key qualifier length
    parameter logic [1:0]  KEY_SEL  = irw_pkg::KEYSEL_0123  // key combination option
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    input  wire logic                   reset_pin_n,      // async reset pin
    input  wire logic [3:0]             key_input_lines,  // async key pins
    input  wire logic                   osc_running,      // async oscillation detect
    input  wire logic                   sec_tick,         // 1 Hz pulse, aclk domain
    output logic                        init_reset,       // combined initial reset
    output logic                        tick_timer_clear, // pulse to clock timer
    output irw_pkg::irw_cpu_init_t      cpu_init,         // cpu start values
    input  wire logic [15:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [15:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    // saturating step toward a limit
    function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic [31:0] lim);
        sat_inc = (v >= lim) ? lim : v + 32'h0000_0001;
    endfunction : sat_inc

    // synchronisers: first stage feeds only the second
    logic [5:0] sync1;                // raw capture: pin, keys, osc
    logic [5:0] sync2;                // safe copies
    logic       pin_s;                // synchronised pin level
    logic [3:0] key_s;                // synchronised keys
    logic       osc_s;                // synchronised oscillation detect
    assign pin_s = sync2[0];
    assign key_s = sync2[4:1];
    assign osc_s = sync2[5];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // pin and keys idle high, osc not yet running; a zero key
            // reset value would look like a press right after reset
            sync1 <= 6'h1F;
            sync2 <= 6'h1F;
        end else if (ce) begin
            sync1 <= {osc_running, key_input_lines, reset_pin_n};
            sync2 <= sync1;
        end
    end

    // key combination chosen by build option
    logic keys_low;                   // all selected keys low together
    always_comb begin
        case (KEY_SEL)
            irw_pkg::KEYSEL_01:   keys_low = (key_s[1:0] == 2'h0);
            irw_pkg::KEYSEL_012:  keys_low = (key_s[2:0] == 3'h0);
            irw_pkg::KEYSEL_0123: keys_low = (key_s == 4'h0);
            default:              keys_low = 1'b0;
        endcase
    end

    // filter counters; a short glitch restarts the count
    logic [31:0] pin_cnt, next_pin_cnt;   // low-time of pin
    logic [31:0] key_cnt, next_key_cnt;   // low-time of keys
    logic        pin_rst, next_pin_rst;   // qualified pin reset
    logic        key_rst, next_key_rst;   // qualified key reset
    always_comb begin
        next_pin_cnt = pin_s ? 32'h0 : sat_inc(pin_cnt, PIN_CYC);
        next_pin_rst = !pin_s && (next_pin_cnt >= PIN_CYC);
        next_key_cnt = keys_low ? sat_inc(key_cnt, KEY_CYC) : 32'h0;
        next_key_rst = keys_low && (next_key_cnt >= KEY_CYC);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_cnt <= 32'h0;
            key_cnt <= 32'h0;
            pin_rst <= 1'b0;
            key_rst <= 1'b0;
        end else if (ce) begin
            pin_cnt <= next_pin_cnt;
            key_cnt <= next_key_cnt;
            pin_rst <= next_pin_rst;
            key_rst <= next_key_rst;
        end
    end

    // bus-side write strobes, decoded below
    logic dog_clr_wr;                 // one written to watchdog clear bit
    logic tmr_clr_wr;                 // one written to timer clear bit

    // watchdog: no halt input on purpose, it keeps counting while halted
    logic [2:0] dog_cnt, next_dog_cnt;    // seconds since last clear
    logic [4:0] dog_hold, next_dog_hold;  // stretch of watchdog reset
    logic       dog_rst, next_dog_rst;    // watchdog reset active
    logic [2:0] dog_sum;                  // count plus this cycle's steps
    always_comb begin
        dog_sum = dog_cnt + {2'b00, sec_tick} + {2'b00, tmr_clr_wr};
        next_dog_hold = (dog_hold != 5'h0) ? dog_hold - 5'h01 : 5'h00;
        next_dog_cnt  = dog_sum;
        if (init_reset || dog_clr_wr) begin
            next_dog_cnt = 3'h0;          // clear restarts at once
        end else if (dog_sum >= irw_pkg::DOG_LIMIT) begin
            next_dog_cnt  = 3'h0;         // fire and start over
            next_dog_hold = 5'(irw_pkg::WDT_HOLD);
        end
        next_dog_rst = (next_dog_hold != 5'h0);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dog_cnt  <= 3'h0;
            dog_hold <= 5'h0;
            dog_rst  <= 1'b0;
        end else if (ce) begin
            dog_cnt  <= next_dog_cnt;
            dog_hold <= next_dog_hold;
            dog_rst  <= next_dog_rst;
        end
    end

    // combined reset; released on a clock edge, never asynchronously
    logic                src_any;     // any source asserting
    irw_pkg::irw_state_t state, next_state;
    always_comb begin
        src_any = pin_rst || key_rst || !osc_s || dog_rst;
        case (state)
            irw_pkg::IRW_RUN:  next_state = src_any ? irw_pkg::IRW_HOLD : irw_pkg::IRW_RUN;
            irw_pkg::IRW_HOLD: next_state = src_any ? irw_pkg::IRW_HOLD : irw_pkg::IRW_RUN;
            default:           next_state = irw_pkg::IRW_HOLD;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= irw_pkg::IRW_HOLD;    // cpu held until sources settle
            init_reset <= 1'b1;                 // asserted out of bus reset
            cpu_init   <= irw_pkg::CPU_INIT;
        end else if (ce) begin
            state      <= next_state;
            // own flop mirrors the hold state, so the pin sees no decode glitch
            init_reset <= (next_state == irw_pkg::IRW_HOLD);
            cpu_init   <= irw_pkg::CPU_INIT;
        end
    end

    // axi4-lite slave: address and data taken in either order
    logic        aw_got, next_aw_got;     // write address held
    logic        w_got, next_w_got;       // write data held
    logic [15:0] aw_adr, next_aw_adr;
    logic [31:0] w_dat, next_w_dat;
    logic [3:0]  w_stb, next_w_stb;
    logic        next_bvalid, next_rvalid, next_tclr;   // registered next values
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        do_write;                // both halves present, no answer pending
    always_comb begin
        do_write    = aw_got && w_got && !s_axi_bvalid;
        next_aw_got = aw_got || (s_axi_awvalid && s_axi_awready);
        next_w_got  = w_got || (s_axi_wvalid && s_axi_wready);
        next_aw_adr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_adr;
        next_w_dat  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_dat;
        next_w_stb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_stb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp  = s_axi_bresp;
        dog_clr_wr  = 1'b0;
        tmr_clr_wr  = 1'b0;
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            if (aw_adr == irw_pkg::CLEAR_ADDR) begin
                next_bresp = irw_pkg::RESP_OKAY;
                // writing zero is no operation
                dog_clr_wr = w_stb[0] && w_dat[irw_pkg::DOG_CLR_BIT];
                tmr_clr_wr = w_stb[0] && w_dat[irw_pkg::TMR_CLR_BIT];
            end else if (aw_adr == irw_pkg::STATUS_ADDR) begin
                next_bresp = irw_pkg::RESP_OKAY;  // read-only, write ignored
            end else begin
                next_bresp = irw_pkg::RESP_SLVERR;
            end
        end
        next_tclr   = tmr_clr_wr;
        // read side: one outstanding read at a time
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = irw_pkg::RESP_OKAY;
            if (s_axi_araddr == irw_pkg::CLEAR_ADDR) begin
                next_rdata = 32'h0;               // write-only bits read zero
            end else if (s_axi_araddr == irw_pkg::STATUS_ADDR) begin
                next_rdata = {24'h0, dog_cnt, !osc_s, key_rst, pin_rst, init_reset, dog_rst};
            end else begin
                next_rdata = 32'h0;
                next_rresp = irw_pkg::RESP_SLVERR;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            aw_adr <= 16'h0;
            w_dat  <= 32'h0;
            w_stb  <= 4'h0;
            s_axi_awready    <= 1'b0;
            s_axi_wready     <= 1'b0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= 2'h0;
            s_axi_arready    <= 1'b0;
            s_axi_rvalid     <= 1'b0;
            s_axi_rresp      <= 2'h0;
            s_axi_rdata      <= 32'h0;
            tick_timer_clear <= 1'b0;
        end else if (ce) begin
            aw_got <= next_aw_got;
            w_got  <= next_w_got;
            aw_adr <= next_aw_adr;
            w_dat  <= next_w_dat;
            w_stb  <= next_w_stb;
            // ready only when the slot is free, so nothing is dropped
            s_axi_awready    <= !next_aw_got && !s_axi_awready;
            s_axi_wready     <= !next_w_got && !s_axi_wready;
            s_axi_bvalid     <= next_bvalid;
            s_axi_bresp      <= next_bresp;
            s_axi_arready    <= !next_rvalid && !s_axi_arready;
            s_axi_rvalid     <= next_rvalid;
            s_axi_rresp      <= next_rresp;
            s_axi_rdata      <= next_rdata;
            tick_timer_clear <= next_tclr;
        end
    end

    // checks
    a_pin_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && pin_s) |=> !pin_rst) else $error("pin reset held while pin high");
    a_pin_filter: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !pin_s && pin_cnt < PIN_CYC - 1) |=> !pin_rst)
        else $error("pin reset before filter time");
    a_key_qual: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !keys_low) |=> (key_cnt == 32'h0 && !key_rst))
        else $error("key reset without all keys low");
    a_key_option: assert property (@(posedge aclk) disable iff (!aresetn)
        (KEY_SEL == irw_pkg::KEYSEL_OFF) |-> !key_rst) else $error("key reset while unused");
    a_osc_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !osc_s) |=> init_reset) else $error("reset released without oscillation");
    a_src_or: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !src_any) ##1 (ce && !src_any) |=> !init_reset)
        else $error("reset held with no source");
    a_dog_fire: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !init_reset && !dog_clr_wr && sec_tick && !tmr_clr_wr
         && dog_cnt == 3'h3) |=> dog_rst ##1 init_reset)
        else $error("watchdog did not fire on fourth tick");
    a_dog_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && dog_clr_wr) |=> (dog_cnt == 3'h0)) else $error("watchdog not cleared");
    a_clear_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == irw_pkg::CLEAR_ADDR)
        |=> (s_axi_rvalid && s_axi_rdata == 32'h0)) else $error("clear register read nonzero");
    a_timer_bump: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && tmr_clr_wr && !dog_clr_wr && !sec_tick && !init_reset && dog_cnt < 3'h3)
        |=> (tick_timer_clear && dog_cnt == $past(dog_cnt) + 3'h1))
        else $error("timer clear did not bump watchdog");
    // filters must also fire once their time is reached, not only stay quiet before
    a_pin_assert: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !pin_s && pin_cnt >= PIN_CYC - 1) |=> pin_rst)
        else $error("pin reset missing after filter time");
    a_key_assert: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && keys_low && key_cnt >= KEY_CYC - 1) |=> key_rst)
        else $error("key reset missing after qualify time");
    a_cpu_values: assert property (@(posedge aclk) disable iff (!aresetn)
        init_reset |-> (cpu_init == irw_pkg::CPU_INIT)) else $error("cpu start values wrong");
    a_ttc_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && tick_timer_clear) |=> !tick_timer_clear)
        else $error("timer clear pulse longer than one cycle");
    c_pin_reset: cover property (@(posedge aclk) disable iff (!aresetn) pin_rst ##1 !pin_rst);
    c_key_reset: cover property (@(posedge aclk) disable iff (!aresetn) key_rst);
    c_dog_reset: cover property (@(posedge aclk) disable iff (!aresetn) $rose(dog_rst));
    c_clear_wr:  cover property (@(posedge aclk) disable iff (!aresetn) dog_clr_wr);
    c_timer_clr: cover property (@(posedge aclk) disable iff (!aresetn) tmr_clr_wr);

endmodule : irw_init_reset

/* sim/irw_ext_model.sv */
// model of the outside reset circuit and the key switches
// assumes the bench calls its tasks right after a rising aclk edge
`timescale 1ns/1ps
module irw_ext_model (
    input  wire logic       aclk,
    output logic            reset_pin_n,    // reset pin, low = reset
    output logic [3:0]      key_input_lines // key pins, low = pressed
);
    // power-on: pin held low from the start, keys released (pulled up)
    initial begin
        reset_pin_n     = 1'b0;
        key_input_lines = 4'hF;
    end

    // end the power-on hold after n cycles, longer than the filter
    task automatic release_pin(input int n);
        repeat (n) @(posedge aclk);
        reset_pin_n <= 1'b1;
    endtask : release_pin

    // pin low for n cycles; a short n is a rejected noise pulse
    task automatic pin_low(input int n);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge aclk);
        reset_pin_n <= 1'b1;
    endtask : pin_low

    // press the keys in mask together for n cycles
    task automatic keys_low(input logic [3:0] mask, input int n);
        key_input_lines <= ~mask;
        repeat (n) @(posedge aclk);
        key_input_lines <= 4'hF;
    endtask : keys_low
endmodule : irw_ext_model

/* sim/irw_init_reset_tb.sv */
// self-checking bench for the initial reset and watchdog block
// assumes short filter counts; register access over AXI4-Lite
`timescale 1ns/1ps
module irw_init_reset_tb;
    localparam int PIN_C = 20;          // shortened pin filter
    localparam int KEY_C = 40;          // shortened key qualifier
    logic        aclk, aresetn, ce, osc_running, sec_tick;
    logic        reset_pin_n;
    logic [3:0]  key_input_lines;
    logic        init_reset, tick_timer_clear, init_reset_off;
    irw_pkg::irw_cpu_init_t cpu_init;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] d;
    int          n_errors, num_checks, n_ttc;

    irw_init_reset #(.PIN_CYC(PIN_C), .KEY_CYC(KEY_C), .KEY_SEL(irw_pkg::KEYSEL_0123)) DUT (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .reset_pin_n(reset_pin_n),
        .key_input_lines(key_input_lines), .osc_running(osc_running),
        .sec_tick(sec_tick), .init_reset(init_reset),
        .tick_timer_clear(tick_timer_clear), .cpu_init(cpu_init),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    irw_ext_model u_ext (
        .aclk(aclk), .reset_pin_n(reset_pin_n), .key_input_lines(key_input_lines));

    // second copy built with the key combination unused: keys never reset it
    irw_init_reset #(.PIN_CYC(PIN_C), .KEY_CYC(KEY_C), .KEY_SEL(irw_pkg::KEYSEL_OFF)) DUT_OFF (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .reset_pin_n(reset_pin_n),
        .key_input_lines(key_input_lines), .osc_running(osc_running),
        .sec_tick(sec_tick), .init_reset(init_reset_off),
        .tick_timer_clear(), .cpu_init(),
        .s_axi_awaddr(16'h0000), .s_axi_awvalid(1'b0), .s_axi_awready(),
        .s_axi_wdata(32'h0000_0000), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
        .s_axi_araddr(16'h0000), .s_axi_arvalid(1'b0), .s_axi_arready(),
        .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0));

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // counts timer clear pulses, one per write of the bit
    always @(posedge aclk) begin
        if (tick_timer_clear === 1'b1) n_ttc++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h, expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
        int  t;
        logic aw, w;
        aw = 0; w = 0; t = 0;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(aw && w) && t < 50) begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) begin aw = 1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w = 1; wvalid <= 1'b0; end
        end
        bready <= 1'b1;
        do begin @(posedge aclk); t++; end while (bvalid !== 1'b1 && t < 100);
        rs = bresp;
        bready <= 1'b0;
        if (t >= 100) begin
            n_errors++;
            $display("Error at %0t: write got no answer", $time);
        end
    endtask : axi_wr

    // read: rready raised once the address is taken, held until rvalid is seen;
    // raising it later keeps back-to-back reads from driving rready twice at one edge
    task automatic axi_rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
        int t;
        t = 0;
        araddr <= a; arvalid <= 1'b1;
        do begin @(posedge aclk); t++; end while (arready !== 1'b1 && t < 50);
        arvalid <= 1'b0; rready <= 1'b1;
        do begin @(posedge aclk); t++; end while (rvalid !== 1'b1 && t < 100);
        v = rdata; rs = rresp;
        rready <= 1'b0;
        if (t >= 100) begin
            n_errors++;
            $display("Error at %0t: read got no answer", $time);
        end
    endtask : axi_rd

    // n 1 Hz tick pulses, each followed by a short gap
    task automatic tick(input int n);
        repeat (n) begin
            sec_tick <= 1'b1;
            @(posedge aclk);
            sec_tick <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask : tick

    // bounded wait for init_reset to reach a level, then compare
    task automatic wait_ir(input logic e, input int n);
        int i;
        for (i = 0; i < n && init_reset !== e; i++) @(posedge aclk);
        check(init_reset, e);
    endtask : wait_ir

    initial begin
        ce = 1'b1; aresetn = 1'b0; osc_running = 1'b0; sec_tick = 1'b0;
        awaddr = '0; araddr = '0; wdata = '0; awvalid = 0; wvalid = 0;
        bready = 0; arvalid = 0; rready = 0;
        n_errors = 0; num_checks = 0; n_ttc = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        u_ext.release_pin(30);
        repeat (10) @(posedge aclk);
        check(init_reset, 1'b1);
        check(32'(cpu_init), 32'(irw_pkg::CPU_INIT));
        osc_running <= 1'b1;
        wait_ir(1'b0, 10);
        $display("power-on test done");
        axi_rd(irw_pkg::CLEAR_ADDR, d, r);
        check(d, 32'h0);
        check(r, irw_pkg::RESP_OKAY);
        axi_rd(16'h0000, d, r);
        check(r, irw_pkg::RESP_SLVERR);
        $display("register test done");
        tick(3);
        check(init_reset, 1'b0);
        axi_rd(irw_pkg::STATUS_ADDR, d, r);
        check(d, 32'h0000_0060);
        axi_wr(irw_pkg::CLEAR_ADDR, 32'h1, r);
        tick(3);
        check(init_reset, 1'b0);
        axi_wr(irw_pkg::CLEAR_ADDR, 32'h0, r);
        check(r, irw_pkg::RESP_OKAY);
        tick(1);
        wait_ir(1'b1, 10);
        wait_ir(1'b0, 40);
        axi_wr(irw_pkg::CLEAR_ADDR, 32'h2, r);
        tick(2);
        check(init_reset, 1'b0);
        check(n_ttc, 1);
        tick(1);
        wait_ir(1'b1, 10);
        wait_ir(1'b0, 40);
        $display("watchdog test done");
        u_ext.pin_low(PIN_C / 2);
        repeat (10) @(posedge aclk);
        check(init_reset, 1'b0);
        u_ext.pin_low(PIN_C + 10);
        check(init_reset, 1'b1);
        wait_ir(1'b0, 10);
        $display("pin test done");
        u_ext.keys_low(4'h7, KEY_C + 20);
        repeat (5) @(posedge aclk);
        check(init_reset, 1'b0);
        u_ext.keys_low(4'hF, KEY_C / 2);
        repeat (5) @(posedge aclk);
        check(init_reset, 1'b0);
        u_ext.keys_low(4'hF, KEY_C + 20);
        check(init_reset, 1'b1);
        check(init_reset_off, 1'b0);
        wait_ir(1'b0, 10);
        $display("key test done");
        finish_test();
    end

    // watchdog against a hang, well beyond the expected run
    initial begin
        #200us;
        n_errors++;
        finish_test();
    end
endmodule : irw_init_reset_tb
